/* bench/clc_cell_regs_props.sv */
// Port-level checker for the logic cell register block
`timescale 1ns/10ps
module clc_cell_regs_props (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // Bus
    input wire clc_pkg::clc_apb_req_t i_apb,
    input wire clc_pkg::clc_apb_rsp_t o_apb,
    // Cell
    input wire logic [clc_pkg::NUM_SRC-1:0] i_cell_in,
    input wire logic o_cell_out,
    input wire logic o_irq
);
    import clc_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire take = i_apb.psel & i_apb.penable & o_apb.pready & i_ce;
    wire rd = take & !i_apb.pwrite;
    wire clr_wr = take & i_apb.pwrite & (i_apb.paddr == OFF_IRQ_CLEAR
        | i_apb.paddr == OFF_IRQ_ENABLE);
    logic [7:0] ctl_q;
    logic ien_q;
    // Shadow of enables, so edge checks know what software asked
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= 8'h00;
            ien_q <= 1'b0;
        end else if (take & i_apb.pwrite) begin
            if (i_apb.paddr == OFF_CONTROL) ctl_q <= i_apb.pwdata[7:0];
            if (i_apb.paddr == OFF_IRQ_ENABLE) ien_q <= i_apb.pwdata[0];
        end
    end
    chk_one_wait: assert property ($rose(i_apb.penable) && i_apb.psel
        |-> !o_apb.pready ##1 o_apb.pready) else $error("pready late");
    chk_status_bit: assert property (
        rd && i_apb.paddr == OFF_CONTROL |-> o_apb.prdata[5] == o_cell_out
        || o_apb.prdata[5] == $past(o_cell_out)) else $error("bad status");
    chk_ctl_unused: assert property (
        rd && i_apb.paddr == OFF_CONTROL |-> !o_apb.prdata[6]
        && o_apb.prdata[31:8] == 24'h0) else $error("ctl bit 6 set");
    chk_pol_unused: assert property (
        rd && i_apb.paddr == OFF_POLARITY |-> o_apb.prdata[6:4] == 3'h0)
        else $error("pol bits 6:4 set");
    chk_sel_unused: assert property (
        rd && i_apb.paddr[7:4] == 4'h1 |-> o_apb.prdata[31:5] == 27'h0)
        else $error("select upper bits set");
    chk_irq_drop: assert property (
        $fell(o_irq) |-> $past(clr_wr) || $past(clr_wr, 2))
        else $error("irq fell without clear");
    chk_off_zero: assert property (
        !ctl_q[7] && $past(!ctl_q[7]) |-> !o_cell_out)
        else $error("disabled cell drives one");
    chk_rise_irq: assert property (
        $rose(o_cell_out) && ctl_q[4] && ien_q |-> o_irq)
        else $error("rise lost");
    chk_fall_irq: assert property (
        $fell(o_cell_out) && ctl_q[3] && ien_q |-> o_irq)
        else $error("fall lost");
endmodule // clc_cell_regs_props
bind clc_cell_regs clc_cell_regs_props u_clc_cell_regs_props (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_apb(i_apb),
    .o_apb(o_apb), .i_cell_in(i_cell_in), .o_cell_out(o_cell_out),
    .o_irq(o_irq));

/* bench/clc_src_model.sv */
// Source side model: on-chip peripherals and pins feeding the cell
`timescale 1ns/10ps
module clc_src_model (
    // Clock and wanted levels
    input wire logic i_clock,
    input wire logic [31:0] i_pat,
    // Levels seen by the cell
    output logic [31:0] o_src
);
    // Sources move just after an edge, like peripheral flops
    always_ff @(posedge i_clock) begin
        o_src <= i_pat;
    end
endmodule // clc_src_model

/* bench/testbench.sv */
// Self-checking bench for the logic cell register block
`timescale 1ns/10ps
module testbench;
    import clc_pkg::*;
    logic i_clock, i_rst;
    clc_apb_req_t req;
    clc_apb_rsp_t o_apb;
    logic [NUM_SRC-1:0] pat_r, src;
    logic o_cell_out, o_irq;
    logic [32:0] exp_q[$];
    int error_cnt, total_checks, seed;
    logic ce;
    // Storing functions: {expected out, mode, polarity}, no routed input
    localparam logic [11:0] SEQ [20] = '{12'hc08, 12'h404, 12'h402,
        12'hc03, 12'hc01, 12'h504, 12'h50a, 12'hd0b, 12'hd09, 12'h604,
        12'h602, 12'he03, 12'he0a, 12'h60b, 12'h704, 12'hf03, 12'h701,
        12'h702, 12'hf03, 12'hf02};
    clc_src_model u_clc_src_model (.i_clock(i_clock), .i_pat(pat_r),
        .o_src(src));
    clc_cell_regs u_clc_cell_regs (.i_clock(i_clock), .i_rst(i_rst),
        .i_ce(ce), .i_apb(req), .o_apb(o_apb), .i_cell_in(src),
        .o_cell_out(o_cell_out), .o_irq(o_irq));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_clock);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            print_verdict();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge i_clock);
        chk("irq", {32'h0, e}, {32'h0, o_irq});
    endtask
    // Reads are judged here, in order of issue
    always @(posedge i_clock) begin
        if (!i_rst && req.psel && req.penable && !req.pwrite
            && o_apb.pready === 1'b1) begin
            if (exp_q.size() == 0) chk("rd_queue", 33'h0, 33'h1);
            else chk("prdata", exp_q.pop_front(),
                {o_apb.pslverr, o_apb.prdata});
        end
    end
    function automatic logic gate_f(input logic [7:0] r, input logic [3:0] d);
        logic g;
        g = (r != 8'h00);
        for (int i = 0; i < 4; i++) begin
            if (r[2*i+1]) g &= d[i];
            if (r[2*i]) g &= ~d[i];
        end
        return g;
    endfunction
    initial begin
        logic [7:0] rt[4];
        logic [4:0] sl[4];
        logic [7:0] pol;
        logic [3:0] d, g;
        logic [2:0] md;
        logic o;
        seed = 12804;
        req = '0;
        ce = 1'b1;
        pat_r = '0;
        i_rst = 1'b1;
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rd(OFF_CONTROL, 33'h0);
        rd(OFF_IRQ_STATUS, 33'h0);
        wr(OFF_POLARITY, 8'hff);
        rd(OFF_POLARITY, 33'h8f);
        wr(OFF_DATA_SEL, 8'hff);
        rd(OFF_DATA_SEL, 33'h1f);
        wr(OFF_CONTROL, 8'h40);
        rd(OFF_CONTROL, 33'h0);
        rd(8'h3c, {1'b1, 32'h0});
        for (int k = 0; k < 24; k++) begin
            pol = $random(seed) & 8'h8f;
            md = 3'({$random(seed)} % 3);
            pat_r <= $random(seed);
            @(posedge i_clock);
            for (int i = 0; i < 4; i++) begin
                sl[i] = $random(seed);
                rt[i] = $random(seed);
                d[i] = pat_r[sl[i]];
                wr(8'(OFF_DATA_SEL + 4 * i), {3'h0, sl[i]});
                wr(8'(OFF_GATE_ROUTE + 4 * i), rt[i]);
            end
            for (int i = 0; i < 4; i++) g[i] = gate_f(rt[i], d) ^ pol[i];
            o = md == 3'h0 ? (g[0] & g[1]) | (g[2] & g[3]) :
                md == 3'h1 ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g;
            o ^= pol[7];
            wr(OFF_POLARITY, pol);
            wr(OFF_CONTROL, {5'h10, md});
            repeat (8) @(posedge i_clock);
            rd(OFF_CONTROL, {25'h0, 2'b10, o, 2'b00, md});
            chk("out", {32'h0, o}, {32'h0, o_cell_out});
        end
        for (int i = 0; i < 4; i++) wr(8'(OFF_GATE_ROUTE + 4 * i), 8'h00);
        wr(OFF_CONTROL, 8'h83);
        for (int j = 0; j < 4; j++) begin
            wr(OFF_POLARITY, j == 2 ? 8'h04 : {7'h0, j == 0});
            repeat (3) @(posedge i_clock);
            rd(OFF_CONTROL, {25'h0, 2'b10, j < 2, 5'h03});
        end
        // Each step builds on the state the previous step left, so order matters
        for (int k = 0; k < 20; k++) begin
            if (SEQ[k][10:8] != md) begin
                md = SEQ[k][10:8];
                wr(OFF_CONTROL, {5'h10, md});
            end
            wr(OFF_POLARITY, SEQ[k][7:0]);
            repeat (2) @(posedge i_clock);
            rd(OFF_CONTROL, {25'h0, 2'b10, SEQ[k][11], 2'b00, md});
        end
        wr(OFF_POLARITY, 8'h00);
        wr(OFF_CONTROL, 8'h92);
        wr(OFF_IRQ_ENABLE, 8'h01);
        irq_is(1'b0);
        wr(OFF_POLARITY, 8'h0f);
        irq_is(1'b1);
        wr(OFF_IRQ_CLEAR, 8'h01);
        irq_is(1'b0);
        wr(OFF_POLARITY, 8'h00);
        irq_is(1'b0);
        wr(OFF_CONTROL, 8'h8a);
        wr(OFF_POLARITY, 8'h0f);
        irq_is(1'b0);
        wr(OFF_POLARITY, 8'h00);
        irq_is(1'b1);
        wr(OFF_IRQ_ENABLE, 8'h00);
        irq_is(1'b0);
        rd(OFF_IRQ_STATUS, 33'h1);
        wr(OFF_IRQ_CLEAR, 8'h01);
        rd(OFF_IRQ_STATUS, 33'h0);
        // Gate 1 follows source 0; the others held high by polarity
        pat_r <= '0;
        wr(OFF_DATA_SEL, 8'h00);
        wr(OFF_GATE_ROUTE, 8'h02);
        wr(OFF_POLARITY, 8'h0e);
        wr(OFF_CONTROL, 8'h9a);
        wr(OFF_IRQ_ENABLE, 8'h01);
        ce <= 1'b0;
        pat_r <= '1;
        repeat (8) @(posedge i_clock);
        chk("frozen", 33'h0, {32'h0, o_cell_out});
        ce <= 1'b1;
        repeat (8) @(posedge i_clock);
        chk("thawed", 33'h1, {32'h0, o_cell_out});
        // Odd spacing makes some clears meet an output edge
        fork
            repeat (40) begin
                pat_r <= ~pat_r;
                repeat (2) @(posedge i_clock);
            end
            repeat (4) begin
                wr(OFF_IRQ_CLEAR, 8'h01);
                @(posedge i_clock);
            end
        join
        irq_is(1'b1);
        wr(OFF_POLARITY, 8'h8c);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rd(OFF_CONTROL, 33'h0);
        rd(OFF_POLARITY, 33'h8c);
        print_verdict();
    end
endmodule // testbench

/* src/clc_cell_regs.sv */
// Configurable logic cell with its APB register file and interrupt
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - Enable bit 7 set combines inputs; clear forces output to zero.
// RULE2 - Control bit 5 is read-only and returns the cell output.
// RULE3 - Rising enable bit 4 lets rising output edges set the flag.
// RULE4 - Falling enable bit 3 lets falling output edges set the flag.
// RULE5 - Codes 000, 001, 010 give AND-OR, OR-XOR and four-input AND.
// RULE6 - Codes 011 to 111 give latch and flip-flop functions.
// RULE7 - Polarity bit 7 inverts the function result.
// RULE8 - Polarity bits 3 to 0 invert gates 4 to 1.
// RULE9 - Control bit 6 and polarity bits 6 to 4 read zero.
// RULE10 - Four source selects hold 5-bit codes; upper bits read zero.
// RULE11 - Gate route bits: odd route true data, even route inverted.
// RULE12 - A cleared route bit keeps that signal out of the gate.
// RULE13 - Gates AND routed signals; with none, polarity sets level.
// RULE14 - Reset clears control only; selection and gating are kept. Code also clears IRQ flag and enable.
// RULE15 - Software clears the flag; a coincident edge keeps it set.
// RULE16 - AND-OR is g1g2 or g3g4; OR-XOR is (g1|g2)^(g3|g4).
module clc_cell_regs (
    // Clock, reset, clock enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // APB slave
    input wire clc_pkg::clc_apb_req_t i_apb,
    output clc_pkg::clc_apb_rsp_t o_apb,
    // Cell sources and results
    input wire logic [clc_pkg::NUM_SRC-1:0] i_cell_in,
    output logic o_cell_out,
    output logic o_irq
);
    import clc_pkg::*;

    // Offset match for a single register
    function automatic logic clc_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        return a == off;
    endfunction

    // Match inside a block of four word registers
    function automatic logic clc_in_block(input logic [7:0] a,
                                          input logic [7:0] base);
        return (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
    endfunction

    // One data gate before its polarity stage
    function automatic logic clc_gate(input logic [7:0] route,
                                      input logic [3:0] d);
        logic [7:0] terms;
        terms = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
        return (|route) & (&(terms | ~route));
    endfunction

    // Source synchronisers and agreement filter
    logic [NUM_SRC-1:0] sync1_q;
    logic [NUM_SRC-1:0] sync2_q;
    logic [NUM_SRC-1:0] sync3_q;
    logic [NUM_SRC-1:0] src_q;
    logic [NUM_SRC-1:0] src_d;
    logic [NUM_SRC-1:0] agree;

    // Registers
    logic [7:0] ctrl_q;
    logic [7:0] pol_q;
    logic [SRC_W-1:0] sel_q [NUM_GATES];
    logic [7:0] route_q [NUM_GATES];
    logic flag_q;
    logic flag_d;
    logic ien_q;
    logic ien_d;
    logic irq_q;

    // Bus
    clc_apb_rsp_t rsp_q;
    logic access;
    logic taken;
    logic wr;
    logic first;
    logic [1:0] sub;
    logic h_ctrl;
    logic h_pol;
    logic h_sel;
    logic h_route;
    logic h_stat;
    logic h_clr;
    logic h_ien;
    logic mapped;
    logic [7:0] ctrl_rd;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    // Cell datapath
    logic [3:0] data;
    logic [3:0] gate_raw;
    logic [3:0] gate;
    logic g1_prev_q;
    logic g1_rise;
    logic state_q;
    logic state_d;
    logic sr_d;
    logic dff1_d;
    logic dff2_d;
    logic jk_next;
    logic jk_d;
    logic lat_d;
    logic and_or;
    logic or_xor;
    logic and4;
    logic [2:0] mode;
    logic func_res;
    logic out_q;
    logic out_d;
    logic rise_ev;
    logic fall_ev;
    logic clr;

    // Pins are asynchronous; a level counts once stages two and three agree
    assign agree = ~(sync2_q ^ sync3_q);
    assign src_d = (sync2_q & agree) | (src_q & ~agree);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            src_q <= '0;
        end else if (i_ce) begin
            sync1_q <= i_cell_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            src_q <= src_d;
        end
    end

    // Bus decode
    assign access = i_apb.psel & i_apb.penable;
    assign first = access & ~rsp_q.pready;
    assign taken = access & rsp_q.pready;
    assign wr = taken & i_apb.pwrite;
    assign wbyte = i_apb.pwdata[7:0];
    assign sub = i_apb.paddr[3:2];
    assign h_ctrl = clc_hit(i_apb.paddr, OFF_CONTROL);
    assign h_pol = clc_hit(i_apb.paddr, OFF_POLARITY);
    assign h_sel = clc_in_block(i_apb.paddr, OFF_DATA_SEL);
    assign h_route = clc_in_block(i_apb.paddr, OFF_GATE_ROUTE);
    assign h_stat = clc_hit(i_apb.paddr, OFF_IRQ_STATUS);
    assign h_clr = clc_hit(i_apb.paddr, OFF_IRQ_CLEAR);
    assign h_ien = clc_hit(i_apb.paddr, OFF_IRQ_ENABLE);
    assign mapped = h_ctrl | h_pol | h_sel | h_route | h_stat | h_clr
                    | h_ien;

    // Live output shown in the status bit
    assign ctrl_rd = ctrl_q | (8'(out_q) << CTRL_OUT_BIT); // RULE2 RULE9

    assign rd_byte = h_ctrl ? ctrl_rd :
                     h_pol ? pol_q : // RULE9
                     h_sel ? {3'h0, sel_q[sub]} : // RULE10
                     h_route ? route_q[sub] :
                     h_stat ? {7'h0, flag_q} :
                     h_ien ? {7'h0, ien_q} :
                     8'h00;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rsp_q.pready <= 1'b0;
            rsp_q.pslverr <= 1'b0;
            rsp_q.prdata <= PRDATA_RST;
        end else if (i_ce) begin
            rsp_q.pready <= first;
            rsp_q.pslverr <= first & ~mapped;
            if (first) begin
                rsp_q.prdata <= {24'h0, rd_byte};
            end
        end
    end

    assign o_apb = rsp_q;

    // Control register resets; of the other registers only the IRQ flag and enable do too
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RST; // RULE14
        end else if (i_ce && wr && h_ctrl) begin
            ctrl_q <= wbyte & CTRL_WMASK; // RULE9
        end
    end

    // Selection, gating and polarity survive reset, undefined at power-up
    always_ff @(posedge i_clock) begin
        if (i_ce && wr && h_pol) begin
            pol_q <= wbyte & POL_WMASK; // RULE9 RULE14
        end
    end

    for (genvar k = 0; k < NUM_GATES; k++) begin : g_cfg
        always_ff @(posedge i_clock) begin
            if (i_ce && wr && h_sel && sub == 2'(k)) begin
                sel_q[k] <= wbyte[SRC_W-1:0]; // RULE10 RULE14
            end
        end

        always_ff @(posedge i_clock) begin
            if (i_ce && wr && h_route && sub == 2'(k)) begin
                route_q[k] <= wbyte; // RULE14
            end
        end

        // Source choice, then gate and its polarity
        assign data[k] = src_q[sel_q[k]]; // RULE10
        assign gate_raw[k] = clc_gate(route_q[k], data); // RULE11 RULE12 RULE13
        assign gate[k] = gate_raw[k] ^ pol_q[k]; // RULE8 RULE13
    end

    // Logic function stage
    assign mode = ctrl_q[2:0];
    assign and_or = (gate[0] & gate[1]) | (gate[2] & gate[3]); // RULE16
    assign or_xor = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // RULE16
    assign and4 = &gate;

    // Gate 1 acts as the storage clock; its edge is seen on i_clock
    assign g1_rise = gate[0] & ~g1_prev_q;

    // Reset input wins over set in every storing function
    assign sr_d = (gate[2] | gate[3]) ? 1'b0 :
                  (gate[0] | gate[1]) ? 1'b1 : state_q; // RULE6
    assign dff1_d = gate[2] ? 1'b0 :
                    gate[3] ? 1'b1 :
                    g1_rise ? gate[1] : state_q; // RULE6
    assign dff2_d = gate[2] ? 1'b0 :
                    g1_rise ? (gate[1] & gate[3]) : state_q; // RULE6
    assign jk_next = (gate[1] & gate[3]) ? ~state_q :
                     gate[1] ? 1'b1 :
                     gate[3] ? 1'b0 : state_q;
    assign jk_d = gate[2] ? 1'b0 :
                  g1_rise ? jk_next : state_q; // RULE6
    assign lat_d = gate[2] ? 1'b0 :
                   gate[3] ? 1'b1 :
                   gate[0] ? gate[1] : state_q; // RULE6

    assign state_d = (mode == MODE_SR_LATCH) ? sr_d :
                     (mode == MODE_DFF_SR) ? dff1_d :
                     (mode == MODE_DFF2_R) ? dff2_d :
                     (mode == MODE_JK_R) ? jk_d :
                     (mode == MODE_LATCH_SR) ? lat_d :
                     state_q;

    // Storing modes use the new state so all modes share one latency
    assign func_res = (mode == MODE_AND_OR) ? and_or :
                      (mode == MODE_OR_XOR) ? or_xor :
                      (mode == MODE_AND4) ? and4 : // RULE5
                      state_d; // RULE6

    assign out_d = ctrl_q[CTRL_EN_BIT]
                   & (func_res ^ pol_q[POL_OUT_BIT]); // RULE1 RULE7

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            g1_prev_q <= 1'b0;
            state_q <= 1'b0;
            out_q <= 1'b0;
        end else if (i_ce) begin
            g1_prev_q <= gate[0];
            // Disabled cell holds no stale storage
            state_q <= ctrl_q[CTRL_EN_BIT] & state_d; // RULE1
            out_q <= out_d; // RULE1
        end
    end

    assign o_cell_out = out_q;

    // Edge events, including those a polarity change causes
    assign rise_ev = ctrl_q[CTRL_INTP_BIT] & out_d & ~out_q; // RULE3
    assign fall_ev = ctrl_q[CTRL_INTN_BIT] & ~out_d & out_q; // RULE4
    assign clr = wr & h_clr & wbyte[0];
    assign flag_d = rise_ev | fall_ev | (flag_q & ~clr); // RULE15
    assign ien_d = (wr && h_ien) ? wbyte[0] : ien_q;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flag_q <= IRQ_FLAG_RST;
            ien_q <= IRQ_EN_RST;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            flag_q <= flag_d; // RULE3 RULE4 RULE15
            ien_q <= ien_d;
            irq_q <= flag_d & ien_d;
        end
    end

    assign o_irq = irq_q;

endmodule // clc_cell_regs

/* src/clc_pkg.sv */
// Package: register map, field positions and types of the logic cell block
package clc_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_POLARITY = 8'h04;
    localparam logic [7:0] OFF_DATA_SEL = 8'h10;
    localparam logic [7:0] OFF_GATE_ROUTE = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h34;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h38;

    // Sizes
    localparam int NUM_SRC = 32;
    localparam int SRC_W = 5;
    localparam int NUM_GATES = 4;

    // Control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_INTP_BIT = 4;
    localparam int CTRL_INTN_BIT = 3;
    localparam logic [7:0] CTRL_WMASK = 8'h9f;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Polarity register fields
    localparam int POL_OUT_BIT = 7;
    localparam logic [7:0] POL_WMASK = 8'h8f;

    // Interrupt and bus response values after reset
    localparam logic IRQ_FLAG_RST = 1'b0;
    localparam logic IRQ_EN_RST = 1'b0;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // Function select codes
    localparam logic [2:0] MODE_AND_OR = 3'h0;
    localparam logic [2:0] MODE_OR_XOR = 3'h1;
    localparam logic [2:0] MODE_AND4 = 3'h2;
    localparam logic [2:0] MODE_SR_LATCH = 3'h3;
    localparam logic [2:0] MODE_DFF_SR = 3'h4;
    localparam logic [2:0] MODE_DFF2_R = 3'h5;
    localparam logic [2:0] MODE_JK_R = 3'h6;
    localparam logic [2:0] MODE_LATCH_SR = 3'h7;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } clc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } clc_apb_rsp_t;

endpackage
